// ### hdl/fwrp_core.v
// fwrp_core.v: quad read with wrap and page program command logic of a serial flash
`include "fwrp_regs.vh"
`default_nettype none

module fwrp_core #(
  parameter MEM_AW   = 16,
  parameter PROT_AW  = 11,
  parameter PROG_CYC = `FWRP_PROG_TIME_US * `FWRP_SYS_MHZ
) (
  // clock, reset, enable
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       ce,
  // serial link pins
  input  wire       spi_clk,
  input  wire       spi_cs_n,
  input  wire [3:0] io_in,
  output reg  [3:0] io_out,
  output reg  [3:0] io_oe,
  // configuration levels
  input  wire       quad_enable_bit,
  input  wire       quad_command_mode,
  input  wire [4:0] block_protect_bits,
  // status
  output reg        write_enable_latch,
  output reg        write_in_progress,
  output reg        wrap_disable_bit,
  output reg  [1:0] wrap_length_field,
  output reg  [1:0] dummy_clock_select,
  output reg        continuous_read_active
);

  localparam ST_IDLE = 10'h001;
  localparam ST_CMD  = 10'h002;
  localparam ST_ADDR = 10'h004;
  localparam ST_MODE = 10'h008;
  localparam ST_DMY  = 10'h010;
  localparam ST_DATA = 10'h020;
  localparam ST_WRAP = 10'h040;
  localparam ST_PPAD = 10'h080;
  localparam ST_PPDT = 10'h100;
  localparam ST_SKIP = 10'h200;

  // ***********************************************
  // storage
  // ***********************************************
  reg  [7:0]   mem [0:(1<<MEM_AW)-1];
  reg  [7:0]   pbuf [0:255];
  reg  [255:0] pvld_r;
  reg  [7:0]   fb [0:1];

  reg  [2:0]  sclk_s;
  reg  [2:0]  csn_s;
  reg  [3:0]  io_s1;
  reg  [3:0]  io_s2;
  reg  [9:0]  st_r;
  reg  [31:0] sh_r;
  reg  [5:0]  cnt_r;
  reg  [7:0]  op_r;
  reg  [3:0]  dcnt_r;
  reg  [23:0] fa_r;
  reg         wp_r;
  reg         rp_r;
  reg  [1:0]  fcnt_r;
  reg         half_r;
  reg  [3:0]  lo_r;
  reg  [23:0] pa_r;
  reg  [7:0]  ptr_r;
  reg         got_r;
  reg         pbusy_r;
  reg  [7:0]  pidx_r;
  reg  [31:0] tmr_r;
  reg  [31:0] sh_nxt;
  reg  [5:0]  cnt_nxt;
  reg  [3:0]  dmy_nxt;
  reg  [23:0] fa_nxt;
  reg  [7:0]  msk;

  wire rise   = ce & sclk_s[1] & ~sclk_s[2];
  wire fall   = ce & ~sclk_s[1] & sclk_s[2];
  wire cs_on  = ce & ~csn_s[1] & csn_s[2];
  wire cs_off = ce & csn_s[1] & ~csn_s[2];
  wire quad   = quad_command_mode | (|(st_r & (ST_ADDR | ST_MODE | ST_DMY)));
  wire in_st  = |(st_r & (ST_CMD | ST_ADDR | ST_MODE | ST_WRAP | ST_PPAD | ST_PPDT));
  wire rd_st  = |(st_r & (ST_DMY | ST_DATA));
  wire fetch  = ce & rd_st & (fcnt_r != 2'h2);
  wire pop    = fall & (st_r == ST_DATA) & ~half_r & (fcnt_r != 2'h0);
  wire [7:0] fhead = fb[rp_r];
  wire [7:0] wbyte = sh_nxt[7:0];
  wire [24:0] plo = (25'h1 << MEM_AW) - ({20'h0, block_protect_bits} << PROT_AW);
  wire prot = (block_protect_bits != 5'h0) & ({1'b0, pa_r} >= plo);
  wire [5:0] wrap_need = quad_command_mode ? `FWRP_CMD_BITS : `FWRP_WRAP_BITS;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  // two flops on each data pin, three on clock and select; only stage two and beyond feed logic
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sclk_s <= 3'h0;
      csn_s  <= 3'h7;
      io_s1  <= 4'h0;
      io_s2  <= 4'h0;
    end else if (ce) begin
      sclk_s <= {sclk_s[1:0], spi_clk};
      csn_s  <= {csn_s[1:0], spi_cs_n};
      io_s1  <= io_in;
      io_s2  <= io_s1;
    end
  end

  // ***********************************************
  // shift, dummy and address helpers
  // ***********************************************
  // sample on rise, one or four lanes
  always @* begin
    sh_nxt  = quad ? {sh_r[27:0], io_s2} : {sh_r[30:0], io_s2[0]};
    cnt_nxt = cnt_r + (quad ? 6'h04 : 6'h01);
    if (op_r == `FWRP_OP_QWORD)
      dmy_nxt = `FWRP_DMY_WORD;
    else if (quad_command_mode) begin
      case (dummy_clock_select)
        2'h0:    dmy_nxt = 4'h4 - `FWRP_MODE_CLKS;
        2'h1:    dmy_nxt = 4'h6 - `FWRP_MODE_CLKS;
        default: dmy_nxt = 4'h8 - `FWRP_MODE_CLKS;
      endcase
    end else begin
      dmy_nxt = `FWRP_DMY_SPI;
    end
    msk = (8'h08 << wrap_length_field) - 8'h01;
    // wrap only in spi with wrap on
    if (!wrap_disable_bit && !quad_command_mode)
      fa_nxt = {fa_r[23:8], (fa_r[7:0] & ~msk) | ((fa_r[7:0] + 8'h01) & msk)};
    else
      fa_nxt = fa_r + 24'h1;
  end

  // ***********************************************
  // command sequencer
  // ***********************************************
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r                   <= ST_IDLE;
      sh_r                   <= 32'h0;
      cnt_r                  <= 6'h0;
      op_r                   <= 8'h00;
      dcnt_r                 <= 4'h0;
      half_r                 <= 1'b0;
      lo_r                   <= 4'h0;
      io_out                 <= 4'h0;
      io_oe                  <= 4'h0;
      pa_r                   <= 24'h0;
      ptr_r                  <= 8'h00;
      got_r                  <= 1'b0;
      write_enable_latch     <= 1'b0;
      wrap_disable_bit       <= `FWRP_RST_WRAP_DIS;
      wrap_length_field      <= `FWRP_RST_WRAP_LEN;
      dummy_clock_select     <= `FWRP_RST_DMY_SEL;
      continuous_read_active <= 1'b0;
    end else if (ce) begin
      if (cs_off) begin
        st_r  <= ST_IDLE;
        io_oe <= 4'h0;
        if (st_r == ST_PPDT && cnt_r == 6'h0 && got_r && !prot && !write_in_progress)
          write_enable_latch <= 1'b0;
      end else if (cs_on) begin
        cnt_r <= 6'h0;
        st_r  <= continuous_read_active ? ST_ADDR : ST_CMD;
      end else if (rise && in_st) begin
        sh_r  <= sh_nxt;
        cnt_r <= cnt_nxt;
        case (st_r)
          ST_CMD: begin
            if (cnt_nxt == `FWRP_CMD_BITS) begin
              cnt_r <= 6'h0;
              op_r  <= wbyte;
              st_r  <= ST_SKIP;
              if (!write_in_progress) begin
                case (wbyte)
                  `FWRP_OP_WR_ENA: write_enable_latch <= 1'b1;
                  `FWRP_OP_PROG: if (write_enable_latch) st_r <= ST_PPAD;
                  `FWRP_OP_QREAD, `FWRP_OP_QWORD: if (quad_enable_bit) st_r <= ST_ADDR;
                  `FWRP_OP_SETWRAP: if (!quad_command_mode) st_r <= ST_WRAP;
                  `FWRP_OP_RDPARAM: if (quad_command_mode) st_r <= ST_WRAP;
                  default: st_r <= ST_SKIP;
                endcase
              end
            end
          end
          ST_ADDR: begin
            if (cnt_nxt == `FWRP_ADDR_BITS) begin
              cnt_r <= 6'h0;
              st_r  <= ST_MODE;
            end
          end
          ST_MODE: begin
            if (cnt_nxt == `FWRP_CMD_BITS) begin
              continuous_read_active <= (wbyte[`FWRP_CRM_HI:`FWRP_CRM_LO] == `FWRP_CRM_KEEP);
              dcnt_r <= dmy_nxt;
              st_r   <= ST_DMY;
            end
          end
          ST_WRAP: begin
            if (cnt_nxt == wrap_need) begin
              st_r <= ST_SKIP;
              if (op_r == `FWRP_OP_SETWRAP) begin
                wrap_disable_bit  <= wbyte[`FWRP_WRAP_DIS_BIT];
                wrap_length_field <= wbyte[`FWRP_WRAP_LEN_HI:`FWRP_WRAP_LEN_LO];
              end else begin
                dummy_clock_select <= wbyte[`FWRP_PAR_DMY_HI:`FWRP_PAR_DMY_LO];
                wrap_length_field  <= wbyte[`FWRP_PAR_LEN_HI:`FWRP_PAR_LEN_LO];
              end
            end
          end
          ST_PPAD: begin
            if (cnt_nxt == `FWRP_ADDR_BITS) begin
              cnt_r <= 6'h0;
              pa_r  <= sh_nxt[23:0];
              ptr_r <= sh_nxt[7:0];
              got_r <= 1'b0;
              st_r  <= ST_PPDT;
            end
          end
          ST_PPDT: begin
            if (cnt_nxt == `FWRP_CMD_BITS) begin
              cnt_r <= 6'h0;
              got_r <= 1'b1;
              ptr_r <= ptr_r + 8'h01;
            end
          end
          default: st_r <= st_r;
        endcase
      end else if (rise && st_r == ST_DMY) begin
        dcnt_r <= dcnt_r - 4'h1;
        half_r <= 1'b0;
        if (dcnt_r == 4'h1)
          st_r <= ST_DATA;
      end else if (fall && st_r == ST_DATA) begin
        // nibble out on fall, high half first
        io_oe  <= 4'hF;
        half_r <= ~half_r;
        io_out <= half_r ? lo_r : fhead[7:4];
        if (!half_r)
          lo_r <= fhead[3:0];
      end
    end
  end

  // ***********************************************
  // read fetch into two-entry buffer
  // ***********************************************
  // fetch stalls while both entries are full, so no byte is lost
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fa_r   <= 24'h0;
      wp_r   <= 1'b0;
      rp_r   <= 1'b0;
      fcnt_r <= 2'h0;
    end else if (ce) begin
      if (rise && st_r == ST_ADDR && cnt_nxt == `FWRP_ADDR_BITS) begin
        fa_r   <= sh_nxt[23:0];
        wp_r   <= 1'b0;
        rp_r   <= 1'b0;
        fcnt_r <= 2'h0;
      end else begin
        if (fetch)
          fa_r <= fa_nxt;
        if (fetch)
          wp_r <= ~wp_r;
        if (pop)
          rp_r <= ~rp_r;
        fcnt_r <= fcnt_r + {1'b0, fetch} - {1'b0, pop};
      end
    end
  end

  // ***********************************************
  // arrays: buffer, page latch, cell array
  // ***********************************************
  always @(posedge sys_clk) begin
    if (ce && fetch)
      fb[wp_r] <= mem[fa_r[MEM_AW-1:0]];
    if (ce && rise && st_r == ST_PPDT && cnt_nxt == `FWRP_CMD_BITS)
      pbuf[ptr_r] <= wbyte;
    if (ce && pbusy_r && pvld_r[pidx_r])
      mem[{pa_r[MEM_AW-1:8], pidx_r}] <= pbuf[pidx_r];
  end

  // ***********************************************
  // self-timed program cycle
  // ***********************************************
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pvld_r            <= 256'h0;
      pbusy_r           <= 1'b0;
      pidx_r            <= 8'h00;
      tmr_r             <= 32'h0;
      write_in_progress <= 1'b0;
    end else if (ce) begin
      if (rise && st_r == ST_PPAD && cnt_nxt == `FWRP_ADDR_BITS)
        pvld_r <= 256'h0;
      else if (rise && st_r == ST_PPDT && cnt_nxt == `FWRP_CMD_BITS)
        pvld_r[ptr_r] <= 1'b1;
      // valid end starts the timed cycle
      if (cs_off && st_r == ST_PPDT && cnt_r == 6'h0 && got_r && !prot &&
          !write_in_progress) begin
        write_in_progress <= 1'b1;
        pbusy_r           <= 1'b1;
        pidx_r            <= 8'h00;
        tmr_r             <= 32'h0;
      end else if (write_in_progress) begin
        tmr_r <= tmr_r + 32'h1;
        if (pbusy_r)
          pidx_r <= pidx_r + 8'h01;
        if (pidx_r == 8'hFF)
          pbusy_r <= 1'b0;
        // busy clears when the time runs out
        if (tmr_r >= PROG_CYC - 1)
          write_in_progress <= 1'b0;
      end
    end
  end

endmodule // fwrp_core

`default_nettype wire

// ### include/fwrp_regs.vh
// fwrp_regs.vh: opcodes, field positions, reset values and timing for the flash command block
`ifndef FWRP_REGS_VH
`define FWRP_REGS_VH

// ***********************************************
// opcodes
// ***********************************************
`define FWRP_OP_WR_ENA    8'h06
`define FWRP_OP_PROG      8'h02
`define FWRP_OP_QREAD     8'hEB
`define FWRP_OP_QWORD     8'hE7
`define FWRP_OP_SETWRAP   8'h77
`define FWRP_OP_RDPARAM   8'hC0

// ***********************************************
// field positions
// ***********************************************
`define FWRP_WRAP_DIS_BIT 4
`define FWRP_WRAP_LEN_HI  6
`define FWRP_WRAP_LEN_LO  5
`define FWRP_PAR_DMY_HI   5
`define FWRP_PAR_DMY_LO   4
`define FWRP_PAR_LEN_HI   1
`define FWRP_PAR_LEN_LO   0
`define FWRP_CRM_HI       5
`define FWRP_CRM_LO       4
`define FWRP_CRM_KEEP     2'h2

// ***********************************************
// reset values
// ***********************************************
`define FWRP_RST_WRAP_DIS 1'h1
`define FWRP_RST_WRAP_LEN 2'h0
`define FWRP_RST_DMY_SEL  2'h0

// ***********************************************
// bit counts and dummy clocks
// ***********************************************
`define FWRP_CMD_BITS     6'h08
`define FWRP_ADDR_BITS    6'h18
`define FWRP_WRAP_BITS    6'h20
`define FWRP_DMY_SPI      4'h4
`define FWRP_DMY_WORD     4'h2
`define FWRP_MODE_CLKS    4'h2

// ***********************************************
// timing
// ***********************************************
`define FWRP_PROG_TIME_US 700
`define FWRP_SYS_MHZ      40

`endif

// ### test/fwrp_props.sv
// fwrp_props.sv: port-level assertions for the flash command block
`default_nettype none
module fwrp_props #(
  parameter int PROG_CYC = 300
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  // link and mode levels
  input wire logic       spi_cs_n,
  input wire logic       quad_command_mode,
  input wire logic [3:0] io_oe,
  // status
  input wire logic       write_enable_latch,
  input wire logic       write_in_progress,
  input wire logic       wrap_disable_bit,
  input wire logic [1:0] dummy_clock_select
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // latch history and busy length; history covers the sync lag between latch and busy
  logic [3:0]  lat_h_r;
  logic [15:0] busy_cnt_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lat_h_r    <= 4'h0;
      busy_cnt_r <= 16'h0000;
    end else begin
      lat_h_r    <= {lat_h_r[2:0], write_enable_latch};
      busy_cnt_r <= write_in_progress ? busy_cnt_r + 16'h0001 : 16'h0000;
    end
  end

  a_idle_no_drive: assert property (spi_cs_n [*6] |-> io_oe == 4'h0)
    else $error("lanes driven while deselected");
  a_oe_all_lanes: assert property (io_oe != 4'h0 |-> io_oe == 4'hF)
    else $error("partial lane enable");
  a_cs_fall_quiet: assert property ($fell(spi_cs_n) |-> (io_oe == 4'h0) [*8])
    else $error("lanes driven before any data phase");
  a_prog_needs_latch: assert property ($rose(write_in_progress) |-> |lat_h_r)
    else $error("program started without latch");
  a_wel_clears: assert property ($rose(write_in_progress) |-> ##[0:4] !write_enable_latch)
    else $error("latch not cleared by program");
  a_prog_length: assert property ($fell(write_in_progress) |->
    busy_cnt_r >= PROG_CYC - 1 && busy_cnt_r <= PROG_CYC + 1)
    else $error("program cycle length wrong");
  a_prog_on_deselect: assert property ($rose(write_in_progress) |-> spi_cs_n)
    else $error("program started while selected");
  a_busy_no_read: assert property (write_in_progress |-> io_oe == 4'h0)
    else $error("read data driven during program");
  a_wrap_spi_only: assert property ($changed(wrap_disable_bit) |-> !quad_command_mode)
    else $error("wrap switch changed in quad mode");
  a_dmy_quad_only: assert property ($changed(dummy_clock_select) |-> quad_command_mode)
    else $error("dummy select changed in spi mode");

  c_prog: cover property ($rose(write_in_progress));
  c_read: cover property (io_oe == 4'hF);
  c_wrap_read: cover property (!wrap_disable_bit && io_oe == 4'hF);
  c_param: cover property ($changed(dummy_clock_select));
endmodule // fwrp_props

bind fwrp_core fwrp_props #(.PROG_CYC(PROG_CYC)) fwrp_props_inst (
  .sys_clk(sys_clk), .rst(rst), .spi_cs_n(spi_cs_n), .quad_command_mode(quad_command_mode),
  .io_oe(io_oe), .write_enable_latch(write_enable_latch),
  .write_in_progress(write_in_progress), .wrap_disable_bit(wrap_disable_bit),
  .dummy_clock_select(dummy_clock_select));
`default_nettype wire

// ### test/fwrp_host.sv
// fwrp_host.sv: behavioural host controller driving the serial flash pins
`default_nettype none
module fwrp_host (
  // link pins
  output var logic       spi_clk,
  output var logic       spi_cs_n,
  output var logic [3:0] io_in,
  input  wire logic [3:0] io_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rbuf [0:15];
  logic [7:0] pbuf [0:511];
  logic [7:0] last_op;
  logic [3:0] q;

  // clock stands low outside frames
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    io_in = 4'h5;
    last_op = 8'hEB;
  end

  // data set while low; read nibble taken just before the next fall
  task automatic ck(input logic [3:0] d);
    io_in = d;
    #100 spi_clk = 1'b1;
    #100 q = io_out;
    spi_clk = 1'b0;
  endtask

  // unused lanes toggle so a stale level is never mistaken for data
  task automatic b1(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) ck({~io_in[3:1], v[i]});
  endtask

  task automatic cs(input logic lvl);
    spi_cs_n = lvl;
    io_in = ~io_in;
    #400;
  endtask

  // one select around opcode, bytes of pbuf, then any stray bits
  task automatic fr(input logic [7:0] op, input int nb, input int x);
    cs(1'b0);
    b1(op);
    for (int i = 0; i < nb; i++) b1(pbuf[i]);
    repeat (x) ck(~io_in);
    cs(1'b1);
  endtask

  // opcode unless skipped, address and mode on four lanes, dummy, data
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                    input int n);
    cs(1'b0);
    if (op != 8'h00) begin
      b1(op);
      last_op = op;
    end
    for (int i = 5; i >= 0; i--) ck(a[i*4+:4]);
    ck(m[7:4]);
    ck(m[3:0]);
    repeat ((last_op == 8'hE7) ? 2 : 4) ck(~io_in);
    for (int i = 0; i < n; i++) begin
      ck(~io_in);
      rbuf[i][7:4] = q;
      ck(~io_in);
      rbuf[i][3:0] = q;
    end
    cs(1'b1);
  endtask

  // parameter frame in quad command mode
  task automatic qp(input logic [7:0] p);
    cs(1'b0);
    ck(4'hC);
    ck(4'h0);
    ck(p[7:4]);
    ck(p[3:0]);
    cs(1'b1);
  endtask
endmodule // fwrp_host
`default_nettype wire

// ### test/tb.sv
// tb.sv: self-checking bench for the flash command block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PC = 300;
  logic       sys_clk, rst, ce, quad_en, qcm, spi_clk, spi_cs_n;
  logic       wlat, busy, wdis, cra;
  logic [1:0] wlen, dsel;
  logic [3:0] io_in, io_out, io_oe;
  logic [4:0] bp;
  logic [7:0] mem [0:255];
  int         seed, failures, num_checks;

  fwrp_core #(.PROG_CYC(PC)) fwrp_core_inst (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable_bit(quad_en),
    .quad_command_mode(qcm), .block_protect_bits(bp), .write_enable_latch(wlat),
    .write_in_progress(busy), .wrap_disable_bit(wdis), .wrap_length_field(wlen),
    .dummy_clock_select(dsel), .continuous_read_active(cra));
  fwrp_host fwrp_host_inst (
    .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out));

  // 40 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // expected cell offset of the i-th byte, wrapped inside its section when w is set
  function automatic logic [7:0] ea(input logic [7:0] a, input logic [7:0] i, input logic w,
                                    input int l);
    logic [7:0] m;
    m = (8'h08 << l) - 8'h01;
    return w ? ((a & ~m) | ((a + i) & m)) : a + i;
  endfunction

  // bounded wait for the program cycle to end, then step off the edge
  task automatic idle;
    for (int k = 0; busy !== 1'b0; k++) begin
      if (k == 400) begin
        failures++;
        summarize;
      end
      @(posedge sys_clk);
    end
    #7;
  endtask

  // random bytes, modelled with in-page address wrap so later bytes win
  task automatic pg(input logic [23:0] a, input int n, input int x, input logic upd);
    logic [7:0] d;
    {fwrp_host_inst.pbuf[0], fwrp_host_inst.pbuf[1], fwrp_host_inst.pbuf[2]} = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      fwrp_host_inst.pbuf[i+3] = d;
      if (upd) mem[8'(a[7:0] + i)] = d;
    end
    fwrp_host_inst.fr(8'h02, n + 3, x);
  endtask

  // wrap frame: three dummy bytes then the wrap byte
  task automatic wr(input logic [7:0] b);
    {fwrp_host_inst.pbuf[0], fwrp_host_inst.pbuf[1], fwrp_host_inst.pbuf[2]} = 24'h000000;
    fwrp_host_inst.pbuf[3] = b;
    fwrp_host_inst.fr(8'h77, 4, 0);
  endtask

  task automatic rdc(input logic [7:0] op, input logic [23:0] a, input logic [7:0] m,
                     input int n, input logic w, input int l);
    fwrp_host_inst.rd(op, a, m, n);
    for (int i = 0; i < n; i++) chk(fwrp_host_inst.rbuf[i], mem[ea(a[7:0], 8'(i), w, l)]);
  endtask

  // hang guard
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    summarize;
  end

  initial begin
    seed = 12125;
    failures = 0;
    num_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    quad_en = 1'b1;
    qcm = 1'b0;
    bp = 5'h00;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #7;
    chk({wlat, busy, wdis, wlen, dsel, cra}, 8'h20);
    pg(24'h000000, 1, 0, 0);
    chk(busy, 1'b0);
    fwrp_host_inst.fr(8'h06, 0, 0);
    chk(wlat, 1'b1);
    bp <= 5'h01;
    pg(24'h00FF00, 1, 0, 0);
    chk({wlat, busy}, 2'h2);
    bp <= 5'h00;
    pg(24'h000000, 1, 3, 0);
    chk({wlat, busy}, 2'h2);
    pg(24'h0000FE, 258, 0, 1);
    chk({wlat, busy}, 2'h1);
    idle;
    fwrp_host_inst.fr(8'h06, 0, 0);
    pg(24'h000003, 1, 0, 1);
    idle;
    rdc(8'hEB, 24'h000004, 8'h00, 8, 1'b0, 0);
    // every wrap length, alternating byte and word reads
    for (int l = 0; l < 4; l++) begin
      wr({1'b0, 2'(l), 5'h00});
      chk({wdis, wlen}, {1'b0, 2'(l)});
      rdc(l % 2 ? 8'hE7 : 8'hEB, 24'((8 << l) - 4), 8'h00, 8, 1'b1, l);
    end
    qcm <= 1'b1;
    chk(wlen, 2'h3);
    // dummy select 01 gives 6 clocks, 4 after the mode byte
    fwrp_host_inst.qp(8'h11);
    chk({dsel, wlen}, 4'h5);
    qcm <= 1'b0;
    rdc(8'hEB, 24'h000006, 8'h20, 2, 1'b1, 1);
    chk(cra, 1'b1);
    // continuous read in quad mode must not wrap although wrap is on
    qcm <= 1'b1;
    rdc(8'h00, 24'h00003C, 8'h20, 8, 1'b0, 0);
    chk(cra, 1'b1);
    rdc(8'h00, 24'h0000F0, 8'h00, 4, 1'b0, 0);
    chk(cra, 1'b0);
    qcm <= 1'b0;
    wr(8'h10);
    chk(wdis, 1'b1);
    rdc(8'hEB, 24'h00007C, 8'h00, 8, 1'b0, 0);
    summarize;
  end
endmodule // tb
`default_nettype wire
